/* File: core/smac_pkg.sv */
package smac_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] SMAC_ADR_INSTR  = 8'h00;
	localparam logic [7:0] SMAC_ADR_OPN    = 8'h04;
	localparam logic [7:0] SMAC_ADR_OPM    = 8'h08;
	localparam logic [7:0] SMAC_ADR_OPA    = 8'h0C;
	localparam logic [7:0] SMAC_ADR_OPHI   = 8'h10;
	localparam logic [7:0] SMAC_ADR_CTRL   = 8'h14;
	localparam logic [7:0] SMAC_ADR_STATUS = 8'h18;
	localparam logic [7:0] SMAC_ADR_RESLO  = 8'h1C;
	localparam logic [7:0] SMAC_ADR_RESHI  = 8'h20;
	localparam logic [31:0] SMAC_RST_WORD  = 32'h0000_0000;

	// ----------------------------------------
	// Control and status bits
	// ----------------------------------------
	localparam int SMAC_CTRL_GO     = 0;
	localparam int SMAC_CTRL_COND   = 1;
	localparam int SMAC_STAT_Q      = 0;
	localparam int SMAC_STAT_BUSY   = 1;
	localparam int SMAC_STAT_UNSUP  = 2;
	localparam int SMAC_STAT_SKIP   = 3;

	// ----------------------------------------
	// Encoding fields
	// ----------------------------------------
	localparam int SMAC_OPC_LSB = 20;
	localparam int SMAC_RN_LSB  = 16;
	localparam int SMAC_RA_LSB  = 12;
	localparam int SMAC_RD_LSB  = 8;
	localparam int SMAC_OP2_LSB = 5;
	localparam int SMAC_SEL_BIT = 4;
	localparam int SMAC_RM_LSB  = 0;
	localparam logic [11:0] SMAC_OPC_WHW  = 12'hFB3;
	localparam logic [11:0] SMAC_OPC_DUAL = 12'hFB4;
	localparam logic [11:0] SMAC_OPC_MLA  = 12'hFB5;
	localparam logic [11:0] SMAC_OPC_MLS  = 12'hFB6;
	localparam logic [11:0] SMAC_OPC_LONG = 12'hFBD;
	localparam logic [2:0]  SMAC_OP2_STD  = 3'h0;
	localparam logic [2:0]  SMAC_OP2_LONG = 3'h6;
	localparam logic [3:0]  SMAC_REG_NONE = 4'hF;
	localparam logic [63:0] SMAC_RND_CONST = 64'h0000_0000_8000_0000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		SMAC_OP_NONE,
		SMAC_OP_WHW,
		SMAC_OP_DUAL_ACC,
		SMAC_OP_DUAL_PLAIN,
		SMAC_OP_DUAL_LONG,
		SMAC_OP_MSW_ACC,
		SMAC_OP_MSW_PLAIN,
		SMAC_OP_MSW_SUB
	} smac_op_t;

	typedef enum logic {
		SMAC_ST_IDLE,
		SMAC_ST_EXEC
	} smac_state_t;

	typedef struct packed {
		smac_op_t   op;
		logic       sel;
		logic [3:0] rn;
		logic [3:0] rm;
		logic [3:0] ra;
		logic [3:0] rd;
	} smac_dec_t;

	typedef struct packed {
		logic        lo_en;
		logic        hi_en;
		logic [3:0]  lo_idx;
		logic [3:0]  hi_idx;
		logic [31:0] lo_data;
		logic [31:0] hi_data;
	} smac_wr_t;

endpackage : smac_pkg

/* File: core/smac_dual_prod.sv */
`timescale 1ns/1ps
module smac_dual_prod
	import smac_pkg::*;
(
	input  wire logic [31:0]        rn_val,
	input  wire logic [31:0]        rm_val,
	input  wire logic               exch,
	output logic signed [32:0]      diff
);

	// ----------------------------------------
	// Halfword products
	// ----------------------------------------
	logic [31:0]        rot;
	logic signed [31:0] p_bot;
	logic signed [31:0] p_top;

	assign rot   = exch ? {rm_val[15:0], rm_val[31:16]} : rm_val;
	assign p_bot = $signed(rn_val[15:0]) * $signed(rot[15:0]);
	assign p_top = $signed(rn_val[31:16]) * $signed(rot[31:16]);
	assign diff  = {p_bot[31], p_bot} - {p_top[31], p_top};

endmodule : smac_dual_prod

/* File: core/smac_core.sv */
`timescale 1ns/1ps
module smac_core
	import smac_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output smac_wr_t         wr_port,
	output logic             sticky_saturation_flag,
	output logic             exec_done
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] smac_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : smac_merge

	function automatic smac_dec_t smac_decode(input logic [31:0] ins);
		smac_dec_t   d;
		logic [11:0] opc;
		logic [2:0]  op2;
		d.op  = SMAC_OP_NONE;
		d.sel = ins[SMAC_SEL_BIT];
		d.rn  = ins[SMAC_RN_LSB +: 4];
		d.rm  = ins[SMAC_RM_LSB +: 4];
		d.ra  = ins[SMAC_RA_LSB +: 4];
		d.rd  = ins[SMAC_RD_LSB +: 4];
		opc   = ins[SMAC_OPC_LSB +: 12];
		op2   = ins[SMAC_OP2_LSB +: 3];
		if (opc == SMAC_OPC_WHW && op2 == SMAC_OP2_STD) begin
			if (d.ra != SMAC_REG_NONE) begin
				d.op = SMAC_OP_WHW;
			end
		end else if (opc == SMAC_OPC_DUAL && op2 == SMAC_OP2_STD) begin
			d.op = (d.ra == SMAC_REG_NONE) ? SMAC_OP_DUAL_PLAIN
			                               : SMAC_OP_DUAL_ACC;
		end else if (opc == SMAC_OPC_LONG && op2 == SMAC_OP2_LONG) begin
			d.op = SMAC_OP_DUAL_LONG;
		end else if (opc == SMAC_OPC_MLA && op2 == SMAC_OP2_STD) begin
			d.op = (d.ra == SMAC_REG_NONE) ? SMAC_OP_MSW_PLAIN
			                               : SMAC_OP_MSW_ACC;
		end else if (opc == SMAC_OPC_MLS && op2 == SMAC_OP2_STD) begin
			d.op = SMAC_OP_MSW_SUB;
		end
		return d;
	endfunction : smac_decode

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] instr_reg;
	logic [31:0] opn_reg;
	logic [31:0] opm_reg;
	logic [31:0] opa_reg;
	logic [31:0] ophi_reg;
	logic [31:0] reslo_reg;
	logic [31:0] reshi_reg;
	logic        cond_reg;
	logic        q_reg;
	logic        unsup_reg;
	logic        skip_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic        done_reg;
	smac_wr_t    wr_reg;
	smac_state_t state_reg;
	smac_state_t state_next;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic        bus_req;
	logic        bus_wr;
	logic        wr_instr;
	logic        wr_opn;
	logic        wr_opm;
	logic        wr_opa;
	logic        wr_ophi;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        go;
	logic        q_clr;
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	assign bus_req  = wb_cyc_i & wb_stb_i;
	assign bus_wr   = bus_req & wb_we_i & ack_reg;
	assign wr_instr = bus_wr & (wb_adr_i == SMAC_ADR_INSTR);
	assign wr_opn   = bus_wr & (wb_adr_i == SMAC_ADR_OPN);
	assign wr_opm   = bus_wr & (wb_adr_i == SMAC_ADR_OPM);
	assign wr_opa   = bus_wr & (wb_adr_i == SMAC_ADR_OPA);
	assign wr_ophi  = bus_wr & (wb_adr_i == SMAC_ADR_OPHI);
	assign wr_ctrl  = bus_wr & (wb_adr_i == SMAC_ADR_CTRL) & wb_sel_i[0];
	assign wr_stat  = bus_wr & (wb_adr_i == SMAC_ADR_STATUS) & wb_sel_i[0];
	assign go       = wr_ctrl & wb_dat_i[SMAC_CTRL_GO]
	                  & (state_reg == SMAC_ST_IDLE);
	assign q_clr    = wr_stat & wb_dat_i[SMAC_STAT_Q];

	always_comb begin
		status_word                 = SMAC_RST_WORD;
		status_word[SMAC_STAT_Q]     = q_reg;
		status_word[SMAC_STAT_BUSY]  = (state_reg != SMAC_ST_IDLE);
		status_word[SMAC_STAT_UNSUP] = unsup_reg;
		status_word[SMAC_STAT_SKIP]  = skip_reg;
	end

	always_comb begin
		case (wb_adr_i)
			SMAC_ADR_INSTR:  rd_mux = instr_reg;
			SMAC_ADR_OPN:    rd_mux = opn_reg;
			SMAC_ADR_OPM:    rd_mux = opm_reg;
			SMAC_ADR_OPA:    rd_mux = opa_reg;
			SMAC_ADR_OPHI:   rd_mux = ophi_reg;
			SMAC_ADR_STATUS: rd_mux = status_word;
			SMAC_ADR_RESLO:  rd_mux = reslo_reg;
			SMAC_ADR_RESHI:  rd_mux = reshi_reg;
			default:         rd_mux = SMAC_RST_WORD;
		endcase
	end

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	smac_dec_t          dec;
	logic [15:0]        hw_sel;
	logic signed [47:0] whw_prod;
	logic [48:0]        whw_sum;
	logic               whw_ovf;
	logic signed [32:0] dual_diff;
	logic [31:0]        dual_acc;
	logic [33:0]        dual_sum;
	logic               dual_ovf;
	logic [63:0]        long_sum;
	logic signed [63:0] msw_prod;
	logic [63:0]        msw_acc;
	logic [63:0]        msw_raw;
	logic [63:0]        msw_res;
	logic               supported;
	smac_wr_t           wr_calc;
	logic               q_calc;

	assign dec      = smac_decode(instr_reg);
	assign hw_sel   = dec.sel ? opm_reg[31:16] : opm_reg[15:0];
	assign whw_prod = $signed(opn_reg) * $signed(hw_sel);
	assign whw_sum  = {whw_prod[47], whw_prod}
	                  + {opa_reg[31], opa_reg, 16'h0000};
	assign whw_ovf  = whw_sum[48] != whw_sum[47];

	smac_dual_prod u_dual (
		.rn_val (opn_reg),
		.rm_val (opm_reg),
		.exch   (dec.sel),
		.diff   (dual_diff)
	);

	assign dual_acc = (dec.op == SMAC_OP_DUAL_ACC) ? opa_reg : SMAC_RST_WORD;
	assign dual_sum = {dual_diff[32], dual_diff}
	                  + {{2{dual_acc[31]}}, dual_acc};
	assign dual_ovf = (dec.op == SMAC_OP_DUAL_ACC)
	                  & ~((dual_sum[33:31] == 3'h0)
	                  | (dual_sum[33:31] == 3'h7));
	assign long_sum = {ophi_reg, opa_reg}
	                  + {{31{dual_diff[32]}}, dual_diff};

	assign msw_prod = $signed(opn_reg) * $signed(opm_reg);
	assign msw_acc  = (dec.op == SMAC_OP_MSW_PLAIN) ? 64'h0
	                  : {opa_reg, SMAC_RST_WORD};
	assign msw_raw  = (dec.op == SMAC_OP_MSW_SUB)
	                  ? msw_acc - msw_prod
	                  : msw_acc + msw_prod;
	assign msw_res  = msw_raw + (dec.sel ? SMAC_RND_CONST : 64'h0);

	assign supported = (dec.op != SMAC_OP_NONE);

	always_comb begin
		wr_calc         = '0;
		wr_calc.lo_en   = supported;
		wr_calc.lo_idx  = dec.rd;
		q_calc          = 1'b0;
		case (dec.op)
			SMAC_OP_WHW: begin
				wr_calc.lo_data = whw_sum[47:16];
				q_calc          = whw_ovf;
			end
			SMAC_OP_DUAL_ACC, SMAC_OP_DUAL_PLAIN: begin
				wr_calc.lo_data = dual_sum[31:0];
				q_calc          = dual_ovf;
			end
			SMAC_OP_DUAL_LONG: begin
				wr_calc.hi_en   = 1'b1;
				wr_calc.lo_idx  = dec.ra;
				wr_calc.hi_idx  = dec.rd;
				wr_calc.lo_data = long_sum[31:0];
				wr_calc.hi_data = long_sum[63:32];
			end
			SMAC_OP_MSW_ACC, SMAC_OP_MSW_PLAIN, SMAC_OP_MSW_SUB: begin
				wr_calc.lo_data = msw_res[63:32];
			end
			default: begin
				wr_calc.lo_en = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic exec;
	logic commit;
	logic q_next;

	assign exec   = (state_reg == SMAC_ST_EXEC);
	assign commit = exec & cond_reg & supported;
	assign q_next = (q_reg & ~q_clr) | (commit & q_calc);

	always_comb begin
		case (state_reg)
			SMAC_ST_IDLE: state_next = go ? SMAC_ST_EXEC : SMAC_ST_IDLE;
			SMAC_ST_EXEC: state_next = SMAC_ST_IDLE;
			default:      state_next = SMAC_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SMAC_ST_IDLE;
			cond_reg  <= 1'b0;
			q_reg     <= 1'b0;
			unsup_reg <= 1'b0;
			skip_reg  <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			q_reg     <= q_next;
			if (go) begin
				cond_reg <= wb_dat_i[SMAC_CTRL_COND];
			end
			if (exec) begin
				unsup_reg <= ~supported;
				skip_reg  <= ~cond_reg;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg    <= '0;
			reslo_reg <= SMAC_RST_WORD;
			reshi_reg <= SMAC_RST_WORD;
		end else if (clk_en) begin
			wr_reg <= commit ? wr_calc : '0;
			if (commit) begin
				reslo_reg <= wr_calc.lo_data;
				reshi_reg <= wr_calc.hi_data;
			end
		end
	end

	// ----------------------------------------
	// Bus registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			dat_reg <= SMAC_RST_WORD;
		end else if (clk_en) begin
			ack_reg <= bus_req & ~ack_reg;
			dat_reg <= rd_mux;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_reg <= SMAC_RST_WORD;
			opn_reg   <= SMAC_RST_WORD;
			opm_reg   <= SMAC_RST_WORD;
			opa_reg   <= SMAC_RST_WORD;
			ophi_reg  <= SMAC_RST_WORD;
		end else if (clk_en) begin
			if (wr_instr) instr_reg <= smac_merge(instr_reg, wb_dat_i, wb_sel_i);
			if (wr_opn)   opn_reg   <= smac_merge(opn_reg, wb_dat_i, wb_sel_i);
			if (wr_opm)   opm_reg   <= smac_merge(opm_reg, wb_dat_i, wb_sel_i);
			if (wr_opa)   opa_reg   <= smac_merge(opa_reg, wb_dat_i, wb_sel_i);
			if (wr_ophi)  ophi_reg  <= smac_merge(ophi_reg, wb_dat_i, wb_sel_i);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o               = ack_reg;
	assign wb_dat_o               = dat_reg;
	assign wr_port                = wr_reg;
	assign sticky_saturation_flag = q_reg;
	assign exec_done              = done_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
		end else if (clk_en) begin
			done_reg <= exec;
		end
	end

endmodule : smac_core

/* File: tb/smac_core_checker.sv */
`timescale 1ns/1ps
module smac_core_checker
	import smac_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        clk_en,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire smac_wr_t    wr_port,
	input wire logic        sticky_saturation_flag,
	input wire logic        exec_done
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire go_w = wb_ack_o && wb_we_i && wb_adr_i == SMAC_ADR_CTRL && wb_dat_i[0];
	wire w1c_w = wb_ack_o && wb_we_i && wb_adr_i == SMAC_ADR_STATUS
		&& wb_dat_i[0] && wb_sel_i[0];
	wire wr_any = wr_port.lo_en || wr_port.hi_en;

	a_ack_one_wait: assert property (clk_en && wb_cyc_i && wb_stb_i
		&& !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_freeze_hold: assert property (!clk_en |=> $stable(wb_ack_o)
		&& $stable(wr_port) && $stable(sticky_saturation_flag))
		else $error("state moved while frozen");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_go_done: assert property (go_w |-> ##2 exec_done)
		else $error("no done two cycles after go");
	a_skip_quiet: assert property (go_w && !wb_dat_i[1] |-> ##2
		!wr_any && $stable(sticky_saturation_flag)) else $error("skip wrote");
	a_write_done: assert property (wr_any |-> exec_done)
		else $error("write without done");
	a_hi_with_lo: assert property (wr_port.hi_en |-> wr_port.lo_en)
		else $error("high word alone");
	a_idle_zero: assert property (!wr_port.lo_en |-> wr_port.lo_data == 32'h0
		&& wr_port.hi_data == 32'h0 && wr_port.lo_idx == 4'h0)
		else $error("idle port not zero");
	a_q_sticky: assert property (sticky_saturation_flag && !w1c_w
		|=> sticky_saturation_flag) else $error("flag lost");
	a_q_rise_exec: assert property ($rose(sticky_saturation_flag)
		|-> exec_done) else $error("flag rose outside exec");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
		&& wb_adr_i > SMAC_ADR_RESHI |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_done_pulse: assert property (exec_done |=> !exec_done)
		else $error("done held");
endmodule : smac_core_checker

bind smac_core smac_core_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wr_port(wr_port), .sticky_saturation_flag(sticky_saturation_flag),
	.exec_done(exec_done));

/* File: tb/smac_rf_model.sv */
`timescale 1ns/1ps
module smac_rf_model
	import smac_pkg::*;
(
	input wire logic     ref_clk,
	input wire logic     rst_n,
	input wire smac_wr_t wr_port,
	output logic         bad_idx
);
	logic [31:0] rf_mem [16];
	wire lo_bad = wr_port.lo_en && wr_port.lo_idx inside {4'hD, 4'hF};
	wire hi_bad = wr_port.hi_en && (wr_port.hi_idx == wr_port.lo_idx
		|| wr_port.hi_idx inside {4'hD, 4'hF});
	// ----
	// Register file write-back
	// ----
	always_ff @(posedge ref_clk) begin
		if (wr_port.lo_en)
			rf_mem[wr_port.lo_idx] <= wr_port.lo_data;
		if (wr_port.hi_en)
			rf_mem[wr_port.hi_idx] <= wr_port.hi_data;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			bad_idx <= 1'b0;
		else if (lo_bad || hi_bad)
			bad_idx <= 1'b1;
	end
endmodule : smac_rf_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench
	import smac_pkg::*;
;
	logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, exp_q = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q, rnd;
	logic wb_ack_o, sticky_saturation_flag, exec_done, bad_idx;
	logic [11:0] opc;
	logic [3:0] ra;
	logic go;
	smac_wr_t wr_port;
	smac_wr_t exp_fifo [$];
	int err_count = 0, comparisons = 0, cycles = 0;
	integer seed = 32'hD9F4AB59;
	logic [11:0] ops [5] = '{SMAC_OPC_WHW, SMAC_OPC_DUAL, SMAC_OPC_MLA,
		SMAC_OPC_MLS, SMAC_OPC_LONG};
	logic [7:0] radr [4] = '{SMAC_ADR_STATUS, SMAC_ADR_RESLO,
		SMAC_ADR_RESHI, 8'h3C};

	smac_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wr_port(wr_port),
		.sticky_saturation_flag(sticky_saturation_flag),
		.exec_done(exec_done));
	smac_rf_model u_rf (.ref_clk(ref_clk), .rst_n(rst_n),
		.wr_port(wr_port), .bad_idx(bad_idx));

	initial forever #25 ref_clk = ~ref_clk;

	// ----
	// Checking and closing
	// ----
	task automatic check(input string nm, input logic [74:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s: expected %h, seen %h", nm, e, g);
		end
	endtask : check

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			give_verdict();
		end
		if (exec_done === 1'b1) begin
			if (exp_fifo.size() == 0)
				check("spare result", 75'h0, 75'h1);
			else
				check("write-back", exp_fifo.pop_front(), wr_port);
		end
	end

	// ----
	// Bus cycles and reference arithmetic
	// ----
	task automatic wb(input logic [7:0] a, input logic we,
		input logic [31:0] d, output logic [31:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge ref_clk);
		while (wb_ack_o !== 1'b1)
			@(posedge ref_clk);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask : wb

	function automatic smac_wr_t model(input logic [31:0] ins, n, m, a, h,
		input logic go, inout logic q);
		smac_wr_t w;
		logic [31:0] m2;
		logic [15:0] hw;
		longint p, r;
		w = '0;
		if (!go || (ins[31:20] == SMAC_OPC_WHW && ins[15:12] == 4'hF))
			return w;
		w.lo_en = 1'b1;
		w.lo_idx = ins[11:8];
		m2 = ins[4] ? {m[15:0], m[31:16]} : m;
		p = longint'($signed(n[15:0])) * $signed(m2[15:0]);
		p -= longint'($signed(n[31:16])) * $signed(m2[31:16]);
		r = longint'($signed(a)) <<< 32;
		if (ins[31:20] == SMAC_OPC_MLA && ins[15:12] == 4'hF)
			r = 0;
		case (ins[31:20])
			SMAC_OPC_WHW: begin
				hw = ins[4] ? m[31:16] : m[15:0];
				r = longint'($signed(n)) * $signed(hw);
				r += longint'($signed(a)) <<< 16;
				w.lo_data = r[47:16];
				q |= (r >>> 16) != longint'($signed(r[47:16]));
			end
			SMAC_OPC_DUAL: begin
				r = p + (ins[15:12] == 4'hF ? 0 : longint'($signed(a)));
				w.lo_data = r[31:0];
				q |= r != longint'($signed(r[31:0]));
			end
			SMAC_OPC_LONG: begin
				r = p + longint'({h, a});
				w.lo_idx = ins[15:12];
				w.hi_en = 1'b1;
				w.hi_idx = ins[11:8];
				w.hi_data = r[63:32];
				w.lo_data = r[31:0];
			end
			default: begin
				p = longint'($signed(n)) * $signed(m);
				r = ins[31:20] == SMAC_OPC_MLS ? r - p : r + p;
				if (ins[4])
					r += 64'h0000_0000_8000_0000;
				w.lo_data = r[63:32];
			end
		endcase
		return w;
	endfunction : model

	function automatic logic [31:0] pickv();
		logic [31:0] r;
		r = $random(seed);
		case (r[1:0])
			2'h0: return 32'h8000_0000;
			2'h1: return 32'h7FFF_FFFF;
			default: return r;
		endcase
	endfunction : pickv

	task automatic run_op(input logic [31:0] ins, n, m, a, h, input logic go);
		logic uns;
		smac_wr_t e;
		uns = ins[31:20] == SMAC_OPC_WHW && ins[15:12] == 4'hF;
		wb(SMAC_ADR_INSTR, 1'b1, ins, rd_q);
		wb(SMAC_ADR_OPN, 1'b1, n, rd_q);
		wb(SMAC_ADR_OPM, 1'b1, m, rd_q);
		wb(SMAC_ADR_OPA, 1'b1, a, rd_q);
		wb(SMAC_ADR_OPHI, 1'b1, h, rd_q);
		e = model(ins, n, m, a, h, go, exp_q);
		exp_fifo.push_back(e);
		wb(SMAC_ADR_CTRL, 1'b1, {30'h0, go, 1'b1}, rd_q);
		wb(SMAC_ADR_STATUS, 1'b0, 32'h0, rd_q);
		check("status", {!go, uns, 1'b0, exp_q}, rd_q[3:0]);
		check("flag", exp_q, sticky_saturation_flag);
		if (e.lo_en) begin
			wb(SMAC_ADR_RESLO, 1'b0, 32'h0, rd_q);
			check("result low", e.lo_data, rd_q);
			wb(SMAC_ADR_RESHI, 1'b0, 32'h0, rd_q);
			check("result high", e.hi_data, rd_q);
			check("reg file", e.lo_data, u_rf.rf_mem[e.lo_idx]);
		end
	endtask : run_op

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		check("reset outputs", 75'h0, {wr_port, sticky_saturation_flag});
		wb(8'h3C, 1'b1, 32'hFFFF_FFFF, rd_q);
		foreach (radr[i]) begin
			wb(radr[i], 1'b0, 32'h0, rd_q);
			check("reset read", SMAC_RST_WORD, rd_q);
		end
		wb_sel_i <= 4'h5;
		wb(SMAC_ADR_OPN, 1'b1, 32'hFFFF_FFFF, rd_q);
		wb_sel_i <= 4'hF;
		wb(SMAC_ADR_OPN, 1'b0, 32'h0, rd_q);
		check("byte lanes", 32'h00FF_00FF, rd_q);
		$display("test reset values done");
		for (int i = 0; i < 80; i++) begin
			rnd = $random(seed);
			opc = ops[rnd[2:0] % 5];
			ra = (rnd[4:3] == 2'h0 && opc != SMAC_OPC_LONG) ? 4'hF
				: {1'b0, rnd[7:5]} + 4'h2;
			go = rnd[12:10] != 3'h0 || ra == 4'hF;
			if (i % 8 == 3) begin
				clk_en <= 1'b0;
				fork
					begin
						repeat (4) @(posedge ref_clk);
						clk_en <= 1'b1;
					end
				join_none
			end
			run_op({opc, 4'h0, ra, 3'b101, rnd[8], opc == SMAC_OPC_LONG
				? SMAC_OP2_LONG : SMAC_OP2_STD, rnd[9], 4'h1},
				pickv(), pickv(), pickv(), pickv(), go);
			if (i % 8 == 7) begin
				wb(SMAC_ADR_STATUS, 1'b1, 32'h1, rd_q);
				exp_q = 1'b0;
				check("flag clear", 1'b0, sticky_saturation_flag);
			end
		end
		$display("test random operations done");
		check("bad index", 1'b0, bad_idx);
		give_verdict();
	end
endmodule : testbench
